/* File: rcs_pkg.sv */
/*
 * rcs_pkg: constants for the reset-cause status block.
 * Assumes a plain register port with 32-bit data and no other users.
 */
`default_nettype none

package rcs_pkg;

    // register map (byte addresses)
    localparam logic [7:0]  ADDR_STATUS = 8'h00;  // reset_cause_status
    localparam logic [7:0]  ADDR_IRQ_ST = 8'h04;  // sticky event status, write one to clear
    localparam logic [7:0]  ADDR_IRQ_MK = 8'h08;  // interrupt mask

    // bit positions of reset_cause_status
    localparam int BIT_HIGH_VOLTAGE_RESET_FLAG  = 29;
    localparam int BIT_CMR   = 9;
    localparam int BIT_VREG  = 8;
    localparam int BIT_PIN   = 7;
    localparam int BIT_SWR   = 6;
    localparam int BIT_WDT   = 4;
    localparam int BIT_SLP   = 3;
    localparam int BIT_IDL   = 2;
    localparam int BIT_BOR   = 1;
    localparam int BIT_POR   = 0;

    // implemented bits: flags set by hardware and the writable control bit
    localparam logic [31:0] FLAG_MASK = 32'h2000_02df;
    localparam logic [31:0] CTRL_MASK = 32'h0000_0100;
    localparam logic [31:0] IMPL_MASK = FLAG_MASK | CTRL_MASK;

    // value after power-on: power-on and brown-out flags read one
    localparam logic [31:0] STATUS_RST = 32'h0000_0003;

    // event vector width: one event per flag bit position (0..29)
    localparam int EV_W = 30;

endpackage : rcs_pkg

`default_nettype wire

/* File: rcs_src_model.sv */
/* rcs_src_model: reset and wake sources standing beside the status block.
   Assumes its inputs change just after the rising edge of clock_i. */
`timescale 1ns/100ps
`default_nettype none

module rcs_src_model (
    input  wire logic       clock_i,             // system clock
    input  wire logic       nrst_i,              // power-on reset, active low
    input  wire logic       nmaster_clear_pin_i, // external reset pin, active low
    input  wire logic       fire_i,              // raise one event this cycle
    input  wire logic [3:0] sel_i,               // event index, 0 to 8
    output logic      [8:0] ev_o                 // hv,cfg,pin,sw,wdt,slp,idl,bor,por
);
    logic pin_q_r; // pin level one cycle ago

    // pin history for falling-edge detection
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_q_r <= 1'b1;
        end else begin
            pin_q_r <= nmaster_clear_pin_i;
        end
    end

    // one-cycle event, or a falling pin seen as a pin reset
    always_comb begin
        ev_o = 9'h000;
        if (fire_i) begin
            ev_o[sel_i] = 1'b1;
        end
        ev_o[2] = ev_o[2] | (pin_q_r & ~nmaster_clear_pin_i);
    end
endmodule // rcs_src_model

`default_nettype wire

/* File: rcs_top.sv */
/*
 * rcs_top: reset-cause and power-state status register with event interrupt.
 * Assumes event inputs are one-cycle pulses synchronous to clock_i, taken from
 * sources that survive the device resets they report; nrst_i is power-on only.
 */
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module rcs_top (
    input  wire logic        clock_i,        // system clock, 25 MHz
    input  wire logic        nrst_i,         // power-on reset, active low
    input  wire logic        en_i,           // clock enable, freezes all state
    input  wire logic        hv_reset_i,     // high-voltage-detect reset event
    input  wire logic        cfg_mm_reset_i, // configuration mismatch reset event
    input  wire logic        pin_reset_i,    // master-clear pin reset event
    input  wire logic        sw_reset_i,     // software reset event
    input  wire logic        wdt_reset_i,    // watchdog time-out event
    input  wire logic        wake_sleep_i,   // wake-up from sleep event
    input  wire logic        wake_idle_i,    // wake-up from idle event
    input  wire logic        bor_reset_i,    // brown-out reset event
    input  wire logic        por_event_i,    // power-on reset seen by monitor
    input  wire logic [7:0]  addr_i,         // register byte address
    input  wire logic [31:0] wdata_i,        // write data
    input  wire logic        wr_i,           // write strobe
    input  wire logic        rd_i,           // read strobe
    output logic      [31:0] rdata_o,        // read data, cycle after rd_i
    output logic             vreg_keep_on_o, // regulator stays on in sleep
    output logic             irq_o           // level interrupt
);

    ////////////////////////////////////////////////////////////////////////////
    // event gathering and write decode

    logic [31:0] status_r;
    logic [31:0] ev_st_r;
    logic [31:0] ev_mk_r;
    logic [31:0] hw_set;
    wire  [31:0] status_nxt;
    logic        wr_status;
    logic        wr_ist;
    logic        wr_imk;

    // decoder shared by every register write and the read mux
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        hit = (a == ref_a);
    endfunction

    assign wr_status = wr_i & hit(addr_i, rcs_pkg::ADDR_STATUS);
    assign wr_ist    = wr_i & hit(addr_i, rcs_pkg::ADDR_IRQ_ST);
    assign wr_imk    = wr_i & hit(addr_i, rcs_pkg::ADDR_IRQ_MK);

    // hardware set vector, one bit per flag position
    always_comb begin
        hw_set = 32'h0000_0000;
        hw_set[rcs_pkg::BIT_HIGH_VOLTAGE_RESET_FLAG] = hv_reset_i;
        hw_set[rcs_pkg::BIT_CMR]  = cfg_mm_reset_i;
        hw_set[rcs_pkg::BIT_PIN]  = pin_reset_i;
        hw_set[rcs_pkg::BIT_SWR]  = sw_reset_i;
        hw_set[rcs_pkg::BIT_WDT]  = wdt_reset_i;
        hw_set[rcs_pkg::BIT_SLP]  = wake_sleep_i;
        hw_set[rcs_pkg::BIT_IDL]  = wake_idle_i;
        hw_set[rcs_pkg::BIT_BOR]  = bor_reset_i;
        hw_set[rcs_pkg::BIT_POR]  = por_event_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // reset-cause status register, one generate slice per bit

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_bit
            if (rcs_pkg::FLAG_MASK[gi]) begin : g_flag
                // sticky flag: set beats software clear
                assign status_nxt[gi] = hw_set[gi]
                                      | (status_r[gi] & (wdata_i[gi] | ~wr_status));
            end else if (rcs_pkg::CTRL_MASK[gi]) begin : g_ctrl
                // plain read/write control bit
                assign status_nxt[gi] = wr_status ? wdata_i[gi] : status_r[gi];
            end else begin : g_none
                // unimplemented: held at zero, writes ignored
                assign status_nxt[gi] = 1'b0;
            end
        end
    endgenerate

    // one register for all slices, so every bit has a single driver
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            status_r <= rcs_pkg::STATUS_RST;
        end else if (en_i) begin
            status_r <= status_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask

    // sticky event bits, write one to clear, new event wins
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ev_st_r <= 32'h0000_0000;
        end else if (en_i) begin
            ev_st_r <= ((ev_st_r & ~(wr_ist ? wdata_i : 32'h0000_0000)) | hw_set)
                       & rcs_pkg::FLAG_MASK;
        end
    end

    // interrupt mask, same layout as the flags
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ev_mk_r <= 32'h0000_0000;
        end else if (en_i && wr_imk) begin
            ev_mk_r <= wdata_i & rcs_pkg::FLAG_MASK;
        end
    end

    // registered interrupt level
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_o <= 1'b0;
        end else if (en_i) begin
            irq_o <= |(ev_st_r & ev_mk_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs: regulator control and read data

    // regulator mode follows the control bit
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vreg_keep_on_o <= 1'b0;
        end else if (en_i) begin
            vreg_keep_on_o <= status_r[rcs_pkg::BIT_VREG];
        end
    end

    // read data valid in the cycle after the strobe, zero after other enabled edges, held while en_i is low
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (en_i) begin
            if (rd_i && hit(addr_i, rcs_pkg::ADDR_STATUS)) begin
                rdata_o <= status_r & rcs_pkg::IMPL_MASK;
            end else if (rd_i && hit(addr_i, rcs_pkg::ADDR_IRQ_ST)) begin
                rdata_o <= ev_st_r;
            end else if (rd_i && hit(addr_i, rcs_pkg::ADDR_IRQ_MK)) begin
                rdata_o <= ev_mk_r;
            end else begin
                rdata_o <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    // each source sets its own flag on the next enabled edge
    hv_flag_set_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && hv_reset_i |=> status_r[rcs_pkg::BIT_HIGH_VOLTAGE_RESET_FLAG])
        else $error("high voltage flag not set");

    cfg_flag_set_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && cfg_mm_reset_i |=> status_r[rcs_pkg::BIT_CMR])
        else $error("mismatch flag not set");

    vreg_follow_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && wr_status ##1 en_i |=> vreg_keep_on_o == $past(wdata_i[rcs_pkg::BIT_VREG], 2))
        else $error("regulator control wrong");

    pin_flag_set_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && pin_reset_i |=> status_r[rcs_pkg::BIT_PIN])
        else $error("pin flag not set");

    sw_flag_set_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && sw_reset_i |=> status_r[rcs_pkg::BIT_SWR])
        else $error("software flag not set");

    wdt_flag_set_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && wdt_reset_i |=> status_r[rcs_pkg::BIT_WDT])
        else $error("watchdog flag not set");

    sleep_flag_set_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && wake_sleep_i |=> status_r[rcs_pkg::BIT_SLP])
        else $error("sleep flag not set");

    idle_flag_set_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && wake_idle_i |=> status_r[rcs_pkg::BIT_IDL])
        else $error("idle flag not set");

    bor_flag_set_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && bor_reset_i |=> status_r[rcs_pkg::BIT_BOR])
        else $error("brown-out flag not set");

    por_flag_set_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && por_event_i |=> status_r[rcs_pkg::BIT_POR])
        else $error("power-on flag not set");

    // a clear flag without its event stays clear
    hv_flag_quiet_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        !hv_reset_i && !status_r[rcs_pkg::BIT_HIGH_VOLTAGE_RESET_FLAG] |=> !status_r[rcs_pkg::BIT_HIGH_VOLTAGE_RESET_FLAG])
        else $error("high voltage flag set without event");

    cfg_flag_quiet_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        !cfg_mm_reset_i && !status_r[rcs_pkg::BIT_CMR] |=> !status_r[rcs_pkg::BIT_CMR])
        else $error("mismatch flag set without event");

    wdt_flag_quiet_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        !wdt_reset_i && !status_r[rcs_pkg::BIT_WDT] |=> !status_r[rcs_pkg::BIT_WDT])
        else $error("watchdog flag set without event");

    // power-on and brown-out flags only drop on a write
    sticky_hold_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        status_r[rcs_pkg::BIT_POR] && !wr_status |=> status_r[rcs_pkg::BIT_POR])
        else $error("power-on flag dropped without write");

    bor_sticky_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        status_r[rcs_pkg::BIT_BOR] && !wr_status |=> status_r[rcs_pkg::BIT_BOR])
        else $error("brown-out flag dropped without write");

    // control bit takes the written value and keeps it between writes
    vreg_write_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && wr_status |=> status_r[rcs_pkg::BIT_VREG] == $past(wdata_i[rcs_pkg::BIT_VREG]))
        else $error("regulator control bit not written");

    vreg_hold_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        !wr_status |=> status_r[rcs_pkg::BIT_VREG] == $past(status_r[rcs_pkg::BIT_VREG]))
        else $error("regulator control bit changed without write");

    unimpl_zero_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        rd_i && hit(addr_i, rcs_pkg::ADDR_STATUS) && en_i |=> rdata_o[31:30] == 2'b00 && !rdata_o[5])
        else $error("unimplemented bits read nonzero");

    clear_works_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && wr_status && !wdata_i[rcs_pkg::BIT_BOR] && !bor_reset_i
        |=> !status_r[rcs_pkg::BIT_BOR])
        else $error("brown-out flag not cleared");

    set_beats_clr_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && wr_status && !wdata_i[rcs_pkg::BIT_WDT] && wdt_reset_i
        |=> status_r[rcs_pkg::BIT_WDT] && ev_st_r[rcs_pkg::BIT_WDT])
        else $error("set lost against clear");

    irq_level_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i |=> irq_o == |($past(ev_st_r) & $past(ev_mk_r)))
        else $error("interrupt level wrong");

    // event status: every event lands, a one written clears
    ev_set_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && (hw_set != 32'h0000_0000) |=> (ev_st_r & $past(hw_set)) == $past(hw_set))
        else $error("event status bit not set");

    ev_clear_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && wr_ist && (hw_set == 32'h0000_0000) |=> (ev_st_r & $past(wdata_i)) == 32'h0000_0000)
        else $error("event status bit not cleared");

    // clock enable low freezes state, read port answers once then idles
    en_freeze_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        !en_i |=> status_r == $past(status_r) && ev_st_r == $past(ev_st_r)
                  && rdata_o == $past(rdata_o))
        else $error("state moved with clock enable low");

    rdata_idle_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && !rd_i |=> rdata_o == 32'h0000_0000)
        else $error("read data not zero without read");

    status_read_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && rd_i && hit(addr_i, rcs_pkg::ADDR_STATUS) |=> rdata_o == ($past(status_r) & rcs_pkg::IMPL_MASK))
        else $error("status read data wrong");

    mask_read_a : assert property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && rd_i && hit(addr_i, rcs_pkg::ADDR_IRQ_MK) |=> rdata_o == $past(ev_mk_r))
        else $error("mask read data wrong");

    // main scenarios the tests should reach
    wake_sleep_c : cover property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && wake_sleep_i ##1 irq_o);
    clear_por_c  : cover property (@(posedge clock_i) disable iff (!nrst_i)
        status_r[rcs_pkg::BIT_POR] ##1 !status_r[rcs_pkg::BIT_POR]);
    read_back_c  : cover property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && rd_i ##1 rdata_o != 32'h0000_0000);
    set_wins_c   : cover property (@(posedge clock_i) disable iff (!nrst_i)
        en_i && wr_status && wdt_reset_i ##1 status_r[rcs_pkg::BIT_WDT]);
    en_freeze_c  : cover property (@(posedge clock_i) disable iff (!nrst_i)
        !en_i && (hw_set != 32'h0000_0000));

endmodule // rcs_top

`default_nettype wire

/* File: tb_top.sv */
/* tb_top: register-port tests of the reset-cause status block.
   Assumes the source model turns commands into one-cycle events. */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    logic        clock_i = 1'b0; // system clock
    logic        nrst_i  = 1'b0; // power-on reset
    logic        en_i    = 1'b1; // clock enable, dropped for one cycle in the freeze test
    logic        npin    = 1'b1; // external reset pin
    logic        fire_i  = 1'b0; // event command
    logic [3:0]  sel_i   = 4'h0; // event index
    logic [7:0]  addr_i  = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic        wr_i    = 1'b0;
    logic        rd_i    = 1'b0;
    logic [31:0] rdata_o;
    logic        vreg_o;
    logic        irq_o;
    logic [8:0]  ev;
    int          miscompares = 0;
    int          compares    = 0;
    int          bitpos [9]  = '{29, 9, 7, 6, 4, 3, 2, 1, 0};

    // 25 MHz clock
    always #20 clock_i = ~clock_i;

    rcs_top i_dut (.clock_i(clock_i), .nrst_i(nrst_i), .en_i(en_i),
        .hv_reset_i(ev[0]), .cfg_mm_reset_i(ev[1]), .pin_reset_i(ev[2]),
        .sw_reset_i(ev[3]), .wdt_reset_i(ev[4]), .wake_sleep_i(ev[5]),
        .wake_idle_i(ev[6]), .bor_reset_i(ev[7]), .por_event_i(ev[8]),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .vreg_keep_on_o(vreg_o), .irq_o(irq_o));
    rcs_src_model i_src (.clock_i(clock_i), .nrst_i(nrst_i),
        .nmaster_clear_pin_i(npin), .fire_i(fire_i), .sel_i(sel_i), .ev_o(ev));

    ////////////////////////////////////////
    // compare and count
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one-cycle write
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    // one-cycle read, data checked in the following cycle
    task rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        chk(name, exp, rdata_o);
    endtask
    // one-cycle event from the source model
    task fire(input logic [3:0] s);
        @(posedge clock_i);
        fire_i <= 1'b1;
        sel_i <= s;
        @(posedge clock_i);
        fire_i <= 1'b0;
    endtask
    // verdict and end of run
    task wrap_up();
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    // main sequence
    initial begin
        repeat (10) @(posedge clock_i);
        nrst_i <= 1'b1;
        rd(rcs_pkg::ADDR_STATUS, rcs_pkg::STATUS_RST, "status_rst");
        rd(rcs_pkg::ADDR_IRQ_ST, 32'h0, "event_rst");
        rd(rcs_pkg::ADDR_IRQ_MK, 32'h0, "mask_rst");
        chk("vreg_rst", 32'h0, {31'h0, vreg_o});
        wr(rcs_pkg::ADDR_STATUS, 32'h0);
        rd(rcs_pkg::ADDR_STATUS, 32'h0, "status_clr");
        wr(rcs_pkg::ADDR_STATUS, 32'hffff_ffff);
        rd(rcs_pkg::ADDR_STATUS, rcs_pkg::CTRL_MASK, "status_ones");
        chk("vreg_on", 32'h1, {31'h0, vreg_o});
        wr(rcs_pkg::ADDR_STATUS, 32'h0);
        rd(rcs_pkg::ADDR_STATUS, 32'h0, "status_zero");
        chk("vreg_off", 32'h0, {31'h0, vreg_o});
        // each source sets its own flag only, then software clears it
        for (int i = 0; i < 9; i++) begin
            if (i == 2) begin
                @(posedge clock_i);
                npin <= 1'b0;
                @(posedge clock_i);
                @(posedge clock_i);
                npin <= 1'b1;
            end else begin
                fire(i[3:0]);
            end
            rd(rcs_pkg::ADDR_STATUS, 32'h1 << bitpos[i], "status_ev");
            wr(rcs_pkg::ADDR_STATUS, 32'h0);
        end
        // event status, mask and interrupt
        rd(rcs_pkg::ADDR_IRQ_ST, rcs_pkg::FLAG_MASK, "event_all");
        chk("irq_masked", 32'h0, {31'h0, irq_o});
        wr(rcs_pkg::ADDR_IRQ_MK, 32'h10);
        rd(rcs_pkg::ADDR_IRQ_MK, 32'h10, "mask_rw");
        chk("irq_on", 32'h1, {31'h0, irq_o});
        wr(rcs_pkg::ADDR_IRQ_ST, 32'hffff_ffef);
        rd(rcs_pkg::ADDR_IRQ_ST, 32'h10, "event_w1c");
        wr(rcs_pkg::ADDR_IRQ_ST, 32'h10);
        rd(rcs_pkg::ADDR_IRQ_ST, 32'h0, "event_clr");
        chk("irq_off", 32'h0, {31'h0, irq_o});
        fire(4'd4);
        @(posedge clock_i);
        #1;
        chk("irq_event", 32'h1, {31'h0, irq_o});
        // hardware set in the same cycle as a clearing write
        wr(rcs_pkg::ADDR_STATUS, 32'h0);
        @(posedge clock_i);
        fire_i <= 1'b1;
        sel_i <= 4'd4;
        wr_i <= 1'b1;
        addr_i <= rcs_pkg::ADDR_STATUS;
        wdata_i <= 32'h0;
        @(posedge clock_i);
        fire_i <= 1'b0;
        wr_i <= 1'b0;
        rd(rcs_pkg::ADDR_STATUS, 32'h10, "set_wins");
        rd(8'h0c, 32'h0, "unmapped");
        // an event while the clock enable is low is not taken
        @(posedge clock_i);
        en_i <= 1'b0;
        fire_i <= 1'b1;
        sel_i <= 4'd3;
        @(posedge clock_i);
        en_i <= 1'b1;
        fire_i <= 1'b0;
        rd(rcs_pkg::ADDR_STATUS, 32'h10, "status_frozen");
        // a second power-on in mid-run brings the power-on value back
        @(posedge clock_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        rd(rcs_pkg::ADDR_STATUS, rcs_pkg::STATUS_RST, "status_rerst");
        rd(rcs_pkg::ADDR_IRQ_ST, 32'h0, "event_rerst");
        wrap_up();
    end

    // hang guard, far beyond the roughly 120 cycles the tests take
    initial begin
        #40000;
        miscompares++;
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
